// >>> rtl/dsf_defs.vh
`ifndef DSF_DEFS_VH
`define DSF_DEFS_VH

// Port widths of the memory device seen from one side.
`define DSF_DATA_W 18
`define DSF_ADDR_W 16
`define DSF_IDX_W 3

// Field positions on the pins.
`define DSF_D0_BIT 0
`define DSF_IDX_MSB 2

// Pin levels, all strobes active low.
`define DSF_ACT 1'b0
`define DSF_INACT 1'b1
`define DSF_FREE_LVL 1'b1
`define DSF_REQ_LVL 1'b0

// Command codes.
`define DSF_CMD_W 2
`define DSF_CMD_WRITE 2'h0
`define DSF_CMD_READ 2'h1
`define DSF_CMD_ACQUIRE 2'h2
`define DSF_CMD_INIT 2'h3

// Phase timing, in clock cycles at 20 MHz.
`define DSF_SETUP_CYC 4'h1
`define DSF_STROBE_CYC 4'h2
`define DSF_GAP_CYC 4'h1
`define DSF_CNT_W 4

// Number of flags and index of the last flag.
`define DSF_NFLAGS 8
`define DSF_LAST_IDX 3'h7

`endif

// >>> rtl/dsf_pin_cycle.v
`timescale 1ns/1ps
`include "dsf_defs.vh"

// ************************************************************
// One strobed pin access to the flag space
// ************************************************************
// The cycle runs setup, strobe and recovery phases. The enable is released at the end of the strobe
// and the select in recovery, so a repeated read always recaptures.
module dsf_pin_cycle
(
    // Clock and reset
    input wire clk,
    input wire srst,
    input wire ce,
    // Request
    input wire start,
    input wire is_write,
    input wire [`DSF_IDX_W-1:0] idx,
    input wire wr_bit,
    // Pins
    input wire [`DSF_DATA_W-1:0] pin_data_i,
    output reg [`DSF_ADDR_W-1:0] pin_addr,
    output reg flag_space_select_n,
    output reg array_enable_n,
    output reg write_n,
    output reg read_enable_n,
    output reg [`DSF_DATA_W-1:0] pin_data_o,
    output reg pin_data_oe,
    // Result
    output reg done,
    output reg rd_bit
);

    localparam S_IDLE = 4'h1;
    localparam S_SETUP = 4'h2;
    localparam S_STROBE = 4'h4;
    localparam S_GAP = 4'h8;

    reg [3:0] st_q;
    reg [`DSF_CNT_W-1:0] cnt_q;
    reg wr_q;

    always @(posedge clk)
    begin
        if (srst)
        begin
            st_q <= S_IDLE;
            cnt_q <= {`DSF_CNT_W{1'b0}};
            wr_q <= 1'b0;
            pin_addr <= {`DSF_ADDR_W{1'b0}};
            flag_space_select_n <= `DSF_INACT;
            array_enable_n <= `DSF_INACT;
            write_n <= `DSF_INACT;
            read_enable_n <= `DSF_INACT;
            pin_data_o <= {`DSF_DATA_W{1'b0}};
            pin_data_oe <= 1'b0;
            done <= 1'b0;
            rd_bit <= 1'b0;
        end
        else if (ce)
        begin
            done <= 1'b0;
            case (st_q)
                S_IDLE:
                begin
                    if (start)
                    begin
                        wr_q <= is_write;
                        // Higher address lines are driven low; the device ignores them.
                        pin_addr <= {{(`DSF_ADDR_W-`DSF_IDX_W){1'b0}}, idx};
                        // Array stays disabled so the access lands only in flag space.
                        array_enable_n <= `DSF_INACT;
                        flag_space_select_n <= `DSF_ACT;
                        pin_data_o <= {{(`DSF_DATA_W-1){1'b0}}, wr_bit};
                        pin_data_oe <= is_write;
                        cnt_q <= `DSF_SETUP_CYC;
                        st_q <= S_SETUP;
                    end
                end
                S_SETUP:
                begin
                    if (cnt_q == `DSF_SETUP_CYC)
                    begin
                        if (wr_q)
                            write_n <= `DSF_ACT;
                        else
                            read_enable_n <= `DSF_ACT;
                        cnt_q <= `DSF_STROBE_CYC;
                        st_q <= S_STROBE;
                    end
                end
                S_STROBE:
                begin
                    if (cnt_q == {`DSF_CNT_W{1'b0}})
                    begin
                        // Write takes effect at the rising edge of the strobe.
                        write_n <= `DSF_INACT;
                        read_enable_n <= `DSF_INACT;
                        // Any data line carries the replicated flag value.
                        if (!wr_q)
                            rd_bit <= pin_data_i[`DSF_D0_BIT];
                        cnt_q <= `DSF_GAP_CYC;
                        st_q <= S_GAP;
                    end
                    else
                    begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                S_GAP:
                begin
                    // Both select and enable go inactive between accesses.
                    flag_space_select_n <= `DSF_INACT;
                    pin_data_oe <= 1'b0;
                    if (cnt_q == {`DSF_CNT_W{1'b0}})
                    begin
                        done <= 1'b1;
                        st_q <= S_IDLE;
                    end
                    else
                    begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default:
                begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end

endmodule // dsf_pin_cycle

// >>> rtl/dsf_host.v
`timescale 1ns/1ps
`include "dsf_defs.vh"

// ************************************************************
// Processor-side controller for the eight flags of one port
// ************************************************************
module dsf_host
(
    // Clock, reset and clock enable
    input wire clk,
    input wire srst,
    input wire ce,
    // Command port
    input wire cmd_valid,
    input wire [`DSF_CMD_W-1:0] cmd_op,
    input wire [`DSF_IDX_W-1:0] flag_index,
    input wire cmd_bit,
    input wire acq_give_up,
    output reg cmd_ready_q,
    output reg rsp_valid_q,
    output reg rsp_bit_q,
    output reg owned_q,
    // Device pins
    input wire [`DSF_DATA_W-1:0] pin_data_i,
    output reg [`DSF_ADDR_W-1:0] pin_addr_q,
    output reg flag_space_select_n_q,
    output reg array_enable_n_q,
    output reg write_n_q,
    output reg read_enable_n_q,
    output reg [`DSF_DATA_W-1:0] pin_data_o_q,
    output reg pin_data_oe_q
);

    localparam H_INIT = 6'h01;
    localparam H_IDLE = 6'h02;
    localparam H_WR = 6'h04;
    localparam H_RD = 6'h08;
    localparam H_ACQ_W = 6'h10;
    localparam H_ACQ_R = 6'h20;

    reg [5:0] st_q;
    reg [5:0] st_d;
    reg [`DSF_IDX_W-1:0] idx_q;
    reg bit_q;
    reg busy_q;
    reg start_d;
    reg is_wr_d;
    reg wr_bit_d;

    wire cyc_done;
    wire cyc_bit;
    wire [`DSF_ADDR_W-1:0] c_addr;
    wire c_sel_n;
    wire c_ae_n;
    wire c_wr_n;
    wire c_oe_n;
    wire [`DSF_DATA_W-1:0] c_do;
    wire c_doe;

    // ************************************************************
    // Sequencer
    // ************************************************************
    always @*
    begin
        st_d = st_q;
        start_d = 1'b0;
        is_wr_d = 1'b0;
        wr_bit_d = `DSF_FREE_LVL;
        case (st_q)
            H_INIT:
            begin
                // Flags are not cleared by the device at power-up.
                start_d = !busy_q;
                is_wr_d = 1'b1;
                wr_bit_d = `DSF_FREE_LVL;
            end
            H_IDLE:
            begin
                if (cmd_valid)
                begin
                    case (cmd_op)
                        `DSF_CMD_WRITE: st_d = H_WR;
                        `DSF_CMD_READ: st_d = H_RD;
                        `DSF_CMD_ACQUIRE: st_d = H_ACQ_W;
                        default: st_d = H_INIT;
                    endcase
                end
            end
            H_WR:
            begin
                start_d = !busy_q;
                is_wr_d = 1'b1;
                wr_bit_d = bit_q;
            end
            H_RD:
            begin
                start_d = !busy_q;
            end
            H_ACQ_W:
            begin
                // Request first; a read before the write would race the other port.
                start_d = !busy_q;
                is_wr_d = 1'b1;
                wr_bit_d = `DSF_REQ_LVL;
            end
            H_ACQ_R:
            begin
                start_d = !busy_q;
            end
            default:
            begin
                st_d = H_INIT;
            end
        endcase
    end

    always @(posedge clk)
    begin
        if (srst)
        begin
            st_q <= H_INIT;
            idx_q <= {`DSF_IDX_W{1'b0}};
            bit_q <= `DSF_FREE_LVL;
            busy_q <= 1'b0;
            cmd_ready_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_bit_q <= `DSF_FREE_LVL;
            owned_q <= 1'b0;
        end
        else if (ce)
        begin
            rsp_valid_q <= 1'b0;
            cmd_ready_q <= 1'b0;
            if (start_d)
                busy_q <= 1'b1;
            else if (cyc_done)
                busy_q <= 1'b0;
            case (st_q)
                H_INIT:
                begin
                    if (cyc_done)
                    begin
                        if (idx_q == `DSF_LAST_IDX)
                        begin
                            st_q <= H_IDLE;
                            cmd_ready_q <= 1'b1;
                            owned_q <= 1'b0;
                        end
                        idx_q <= idx_q + 1'b1;
                    end
                end
                H_IDLE:
                begin
                    cmd_ready_q <= !cmd_valid;
                    if (cmd_valid)
                    begin
                        idx_q <= (cmd_op == `DSF_CMD_INIT) ? {`DSF_IDX_W{1'b0}} : flag_index;
                        bit_q <= cmd_bit;
                    end
                    st_q <= st_d;
                end
                H_ACQ_W:
                begin
                    if (cyc_done)
                        st_q <= H_ACQ_R;
                end
                H_ACQ_R:
                begin
                    if (cyc_done)
                    begin
                        if (cyc_bit == `DSF_REQ_LVL || !acq_give_up)
                        begin
                            // Keep polling; a pending request is only abandoned when acq_give_up is set.
                            if (cyc_bit == `DSF_REQ_LVL)
                            begin
                                rsp_valid_q <= 1'b1;
                                rsp_bit_q <= cyc_bit;
                                owned_q <= 1'b1;
                                cmd_ready_q <= 1'b1;
                                st_q <= H_IDLE;
                            end
                        end
                        else
                        begin
                            // Withdraw the request by releasing the latch.
                            bit_q <= `DSF_FREE_LVL;
                            rsp_bit_q <= cyc_bit;
                            st_q <= H_WR;
                        end
                    end
                end
                H_WR, H_RD:
                begin
                    if (cyc_done)
                    begin
                        rsp_valid_q <= 1'b1;
                        rsp_bit_q <= (st_q == H_RD) ? cyc_bit : bit_q;
                        if (st_q == H_WR && bit_q == `DSF_FREE_LVL)
                            owned_q <= 1'b0;
                        cmd_ready_q <= 1'b1;
                        st_q <= H_IDLE;
                    end
                end
                default:
                begin
                    st_q <= H_INIT;
                end
            endcase
        end
    end

    // ************************************************************
    // Pin cycle engine
    // ************************************************************
    dsf_pin_cycle u_cyc
    (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .start(start_d && ce),
        .is_write(is_wr_d),
        .idx(idx_q),
        .wr_bit(wr_bit_d),
        .pin_data_i(pin_data_i),
        .pin_addr(c_addr),
        .flag_space_select_n(c_sel_n),
        .array_enable_n(c_ae_n),
        .write_n(c_wr_n),
        .read_enable_n(c_oe_n),
        .pin_data_o(c_do),
        .pin_data_oe(c_doe),
        .done(cyc_done),
        .rd_bit(cyc_bit)
    );

    // Outputs are re-registered here so every top port comes from a flip-flop.
    always @(posedge clk)
    begin
        if (srst)
        begin
            pin_addr_q <= {`DSF_ADDR_W{1'b0}};
            flag_space_select_n_q <= `DSF_INACT;
            array_enable_n_q <= `DSF_INACT;
            write_n_q <= `DSF_INACT;
            read_enable_n_q <= `DSF_INACT;
            pin_data_o_q <= {`DSF_DATA_W{1'b0}};
            pin_data_oe_q <= 1'b0;
        end
        else if (ce)
        begin
            pin_addr_q <= c_addr;
            flag_space_select_n_q <= c_sel_n;
            array_enable_n_q <= c_ae_n;
            write_n_q <= c_wr_n;
            read_enable_n_q <= c_oe_n;
            pin_data_o_q <= c_do;
            pin_data_oe_q <= c_doe;
        end
    end

endmodule // dsf_host

// >>> tb/dsf_host_props.sv
`timescale 1ns/1ps
`include "dsf_defs.vh"
// ********************
// Pin checks of the flag host
// ********************
module dsf_host_props
(
    // Clock and reset
    input wire clk,
    input wire srst,
    // Status
    input wire cmd_ready_q,
    input wire rsp_valid_q,
    // Pins
    input wire [`DSF_ADDR_W-1:0] pin_addr_q,
    input wire flag_space_select_n_q,
    input wire array_enable_n_q,
    input wire write_n_q,
    input wire read_enable_n_q,
    input wire [`DSF_DATA_W-1:0] pin_data_o_q,
    input wire pin_data_oe_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_strobe;
        !write_n_q || !read_enable_n_q;
    endsequence
    sequence s_write_end;
        $rose(write_n_q);
    endsequence
    // The write strobe has to end inside a short window, or a wedged write cycle would pass unseen.
    sequence s_strobe_ends;
        1'b1 ##[1:6] write_n_q;
    endsequence
    a_array_kept_off: assert property (array_enable_n_q)
        else $error("array enable asserted");
    a_strobe_needs_select: assert property (s_strobe |-> !flag_space_select_n_q)
        else $error("strobe outside select");
    a_strobes_exclusive: assert property (!(!write_n_q && !read_enable_n_q))
        else $error("write and read together");
    a_high_addr_zero: assert property (!flag_space_select_n_q |-> pin_addr_q[15:3] == 13'h0)
        else $error("upper address bits set");
    a_data_bit_zero: assert property (pin_data_oe_q |-> pin_data_o_q[17:1] == 17'h0)
        else $error("upper data bits driven");
    a_write_data_held: assert property ($fell(write_n_q) |-> (pin_data_oe_q && !flag_space_select_n_q) throughout s_strobe_ends)
        else $error("write data dropped during strobe");
    a_trailing_edge_data: assert property (s_write_end |-> pin_data_oe_q && !flag_space_select_n_q && $stable(pin_data_o_q))
        else $error("data moved at write edge");
    a_poll_releases: assert property ($rose(read_enable_n_q) |-> ##[0:3] flag_space_select_n_q)
        else $error("select held between reads");
    a_answer_after_cycle: assert property (rsp_valid_q |-> flag_space_select_n_q && write_n_q && read_enable_n_q)
        else $error("answer before pins released");
    a_idle_standby: assert property (cmd_ready_q |-> flag_space_select_n_q && !pin_data_oe_q)
        else $error("pins active while idle");
endmodule // dsf_host_props
bind dsf_host dsf_host_props dsf_host_props_inst (.clk, .srst, .cmd_ready_q, .rsp_valid_q, .pin_addr_q,
    .flag_space_select_n_q, .array_enable_n_q, .write_n_q, .read_enable_n_q, .pin_data_o_q, .pin_data_oe_q);

// >>> tb/dsf_dev_model.sv
`timescale 1ns/1ps
`include "dsf_defs.vh"
// ********************
// Two-port flag device
// ********************
module dsf_dev_model
(
    // Host side
    input wire logic [`DSF_ADDR_W-1:0] l_addr,
    input wire logic l_sel_n,
    input wire logic l_arr_n,
    input wire logic l_we_n,
    input wire logic l_oe_n,
    input wire logic [`DSF_DATA_W-1:0] l_d,
    output logic [`DSF_DATA_W-1:0] l_q,
    // Far side, driven by the bench
    input wire logic [`DSF_IDX_W-1:0] r_idx,
    input wire logic r_sel_n,
    input wire logic r_we_n,
    input wire logic r_oe_n,
    input wire logic r_d0,
    output logic [`DSF_DATA_W-1:0] r_q
);
    // Host latches come up as requests, so a missing start-up release shows.
    logic [7:0] req_l = 8'h00;
    logic [7:0] req_r = 8'hff;
    logic [7:0] own_l = 8'h00;
    logic [7:0] own_r = 8'h00;
    logic lat_l = 1'b1;
    logic lat_r = 1'b1;
    // The writer's side settles first, so a release hands a pending request the token at once.
    task automatic put(input bit left, input logic [2:0] i, input logic v);
        if (left)
            req_l[i] = v;
        else
            req_r[i] = v;
        if (left)
            own_l[i] = own_l[i] ? !req_l[i] : !req_l[i] && !own_r[i];
        own_r[i] = own_r[i] ? !req_r[i] : !req_r[i] && !own_l[i];
        own_l[i] = own_l[i] ? !req_l[i] : !req_l[i] && !own_r[i];
    endtask
    always @(posedge l_we_n)
        if (!l_sel_n && l_arr_n)
            put(1'b1, l_addr[2:0], l_d[0]);
    always @(posedge r_we_n)
        if (!r_sel_n)
            put(1'b0, r_idx, r_d0);
    always @(negedge (l_sel_n | l_oe_n))
        if (l_arr_n)
            lat_l = !own_l[l_addr[2:0]];
    always @(negedge (r_sel_n | r_oe_n))
        lat_r = !own_r[r_idx];
    // A released bus shows the inverse of the last read, never a settled unknown.
    assign l_q = (!l_sel_n && !l_oe_n && l_arr_n) ? {`DSF_DATA_W{lat_l}} : {`DSF_DATA_W{!lat_l}};
    assign r_q = (!r_sel_n && !r_oe_n) ? {`DSF_DATA_W{lat_r}} : {`DSF_DATA_W{!lat_r}};
endmodule // dsf_dev_model

// >>> tb/dual_port_semaphore_flags_bench.sv
`timescale 1ns/1ps
`include "dsf_defs.vh"
module dual_port_semaphore_flags_bench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic cmd_valid = 1'b0;
    logic [`DSF_CMD_W-1:0] cmd_op = 2'h0;
    logic [`DSF_IDX_W-1:0] flag_index = 3'h0;
    logic cmd_bit = 1'b0;
    logic acq_give_up = 1'b0;
    logic ce = 1'b1;
    logic cmd_ready_q, rsp_valid_q, rsp_bit_q, owned_q, sel_n, arr_n, we_n, oe_n, pin_data_oe_q, rb;
    logic [`DSF_ADDR_W-1:0] pin_addr_q;
    logic [`DSF_DATA_W-1:0] pin_data_o_q, dev_q, r_q, q;
    logic [2:0] r_idx = 3'h0;
    logic r_sel_n = 1'b1;
    logic r_we_n = 1'b1;
    logic r_oe_n = 1'b1;
    logic r_d0 = 1'b1;
    int n_mismatch = 0;
    int total_checks = 0;
    // Row layout: command, flag, written bit, expected answer, expected host ownership.
    logic [7:0] rows [9] = '{8'h01, 8'h41, 8'h06, 8'h42, 8'hb9, 8'h79, 8'h3e, 8'h99, 8'h1e};
    wire [`DSF_DATA_W-1:0] bus = pin_data_oe_q ? pin_data_o_q : dev_q;
    always #25 clk = ~clk;
    dsf_host dsf_host_inst (.clk, .srst, .ce(ce), .cmd_valid, .cmd_op, .flag_index, .cmd_bit, .acq_give_up,
        .cmd_ready_q, .rsp_valid_q, .rsp_bit_q, .owned_q, .pin_data_i(bus), .pin_addr_q,
        .flag_space_select_n_q(sel_n), .array_enable_n_q(arr_n), .write_n_q(we_n), .read_enable_n_q(oe_n),
        .pin_data_o_q, .pin_data_oe_q);
    dsf_dev_model dsf_dev_model_inst (.l_addr(pin_addr_q), .l_sel_n(sel_n), .l_arr_n(arr_n), .l_we_n(we_n),
        .l_oe_n(oe_n), .l_d(bus), .l_q(dev_q), .r_idx, .r_sel_n, .r_we_n, .r_oe_n, .r_d0, .r_q);
    task automatic chk(input logic [`DSF_DATA_W-1:0] got, input logic [`DSF_DATA_W-1:0] exp, input string msg);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic wready();
        @(posedge clk) #2;
        repeat (400) if (cmd_ready_q !== 1'b1) @(posedge clk) #2;
        chk(cmd_ready_q, 1'b1, "host never ready");
    endtask
    task automatic cmd(input logic [1:0] op, input logic [2:0] i, input logic b);
        wready();
        cmd_op = op;
        flag_index = i;
        cmd_bit = b;
        cmd_valid = 1'b1;
        repeat (20) if (cmd_ready_q === 1'b1) @(posedge clk) #2;
        cmd_valid = 1'b0;
        if (op == `DSF_CMD_INIT)
            return;
        repeat (400) if (rsp_valid_q !== 1'b1) @(posedge clk) #2;
        chk(rsp_valid_q, 1'b1, "no answer");
        rb = rsp_bit_q;
    endtask
    // The far side holds select across the strobe and drops it one cycle later, as a processor would.
    task automatic rside(input logic [2:0] i, input logic wr, input logic b, output logic [`DSF_DATA_W-1:0] v);
        @(posedge clk) #2;
        r_idx = i;
        r_d0 = b;
        r_sel_n = 1'b0;
        @(posedge clk) #2;
        r_we_n = !wr;
        r_oe_n = wr;
        @(posedge clk) #2;
        v = r_q;
        r_we_n = 1'b1;
        r_oe_n = 1'b1;
        @(posedge clk) #2;
        r_sel_n = 1'b1;
        r_d0 = !b;
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        #2 chk({sel_n, we_n, oe_n, cmd_ready_q}, 4'he, "pins during reset");
        repeat (10) @(posedge clk);
        #2 srst = 1'b0;
        wready();
        chk(dsf_dev_model_inst.req_l, 8'hff, "start-up release");
        foreach (rows[n])
        begin
            cmd(rows[n][7:6], rows[n][5:3], rows[n][2]);
            chk(rb, rows[n][1], "row answer");
            chk(dsf_dev_model_inst.own_l[rows[n][5:3]], rows[n][0], "row owner");
        end
        rside(3'h2, 1'b1, 1'b0, q);
        cmd(`DSF_CMD_READ, 3'h2, 1'b0);
        chk(rb, 1'b1, "far side owns");
        rside(3'h2, 1'b0, 1'b0, q);
        chk(q, 18'h00000, "owner reads zeros");
        acq_give_up = 1'b1;
        cmd(`DSF_CMD_ACQUIRE, 3'h2, 1'b0);
        chk(rb, 1'b1, "acquire refused");
        chk(dsf_dev_model_inst.req_l[2], 1'b1, "request withdrawn");
        acq_give_up = 1'b0;
        cmd(`DSF_CMD_WRITE, 3'h2, 1'b0);
        chk(dsf_dev_model_inst.req_l[2], 1'b0, "request pending");
        cmd(`DSF_CMD_READ, 3'h2, 1'b0);
        chk(rb, 1'b1, "pending reads one");
        rside(3'h2, 1'b1, 1'b1, q);
        cmd(`DSF_CMD_READ, 3'h2, 1'b0);
        chk(rb, 1'b0, "token handed over");
        rside(3'h2, 1'b0, 1'b0, q);
        chk(q, 18'h3ffff, "loser reads ones");
        cmd(`DSF_CMD_WRITE, 3'h2, 1'b1);
        rside(3'h2, 1'b1, 1'b0, q);
        fork
            cmd(`DSF_CMD_ACQUIRE, 3'h2, 1'b0);
            #4000 rside(3'h2, 1'b1, 1'b1, q);
        join
        chk({rb, owned_q}, 2'h1, "acquire after polling");
        // A pending command must not start a pin cycle while the clock enable is low.
        ce = 1'b0;
        cmd_op = `DSF_CMD_READ;
        flag_index = 3'h0;
        cmd_valid = 1'b1;
        repeat (5) @(posedge clk);
        #2 chk({cmd_ready_q, sel_n, oe_n, we_n}, 4'hf, "clock enable did not freeze");
        cmd_valid = 1'b0;
        ce = 1'b1;
        cmd(`DSF_CMD_INIT, 3'h0, 1'b0);
        wready();
        chk({dsf_dev_model_inst.req_l, dsf_dev_model_inst.own_l[2]}, 9'h1fe, "init releases all");
        results();
    end
    initial
    begin
        #(50 * 8000);
        n_mismatch++;
        $display("[ERR] %0t watchdog expired", $time);
        results();
    end
endmodule // dual_port_semaphore_flags_bench
